// ---- bidir_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module bidir_port
    import port_pkg::*;
(
    input  wire  logic              core_clk,
    input  wire  logic              srst,
    input  wire  logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire  logic              s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire  logic [31:0]       s_axi_wdata,
    input  wire  logic [3:0]        s_axi_wstrb,
    input  wire  logic              s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire  logic              s_axi_bready,
    input  wire  logic [AXI_AW-1:0] s_axi_araddr,
    input  wire  logic              s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire  logic              s_axi_rready,
    input  wire  logic [PORT_W-1:0] pin_in,
    output logic       [PORT_W-1:0] pin_out,
    output logic       [PORT_W-1:0] pin_oe,
    output logic       [PORT_W-1:0] pullup_en,
    input  wire  logic              prog_mode,
    input  wire  logic              prog_data_out,
    input  wire  logic              prog_data_oe,
    output logic                    pin6_prog_clock,
    output logic                    pin7_prog_data,
    output logic                    irq
);
    logic [PORT_W-1:0] pin_s;
    logic [PORT_W-1:0] latch_q;
    logic [PORT_W-1:0] sample_q;
    logic [PORT_W-1:0] second_port_direction_q;
    logic [PORT_W-1:0] timer_pullup_config_q;
    logic [PORT_W-1:0] pend_val_q;
    logic              pend_q;
    logic [3:4-4]      snap_q;
    logic              pin0_prev_q;
    logic [ST_W-1:0]   status_q;
    logic [ST_W-1:0]   mask_q;
    logic [1:0]        div_q;
    logic              cyc_start;
    logic              cyc_end;
    logic              aw_got_q;
    logic              w_got_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic              wlane0_q;
    logic              do_write;
    logic              rd_take;
    logic              port_wr;
    logic              port_rd;
    logic              mismatch;
    logic              ext_edge;
    logic [PORT_W-1:0] dir_eff;
    logic [PORT_W-1:0] bit_mask;
    logic [PORT_W-1:0] rmw_val;

    pin_sync #(
        .WIDTH(PORT_W)
    ) u_sync (
        .core_clk(core_clk),
        .srst    (srst),
        .async_in(pin_in),
        .stable_q(pin_s)
    );

    // instruction cycle: start and end enables from a free divider
    always_ff @(posedge core_clk) begin
        if (srst) begin
            div_q <= '0;
        end else begin
            div_q <= (div_q == 2'(INSTR_CLKS - 1)) ? 2'b00 : div_q + 2'b01;
        end
    end
    assign cyc_start = (div_q == 2'b00);
    assign cyc_end   = (div_q == 2'(INSTR_CLKS - 1));

    // bus write channel: address and data taken in either order
    assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wlane0_q      <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q      <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_got_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q      <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wlane0_q     <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_got_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (do_write) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    A_PORT_DATA, A_OPTION, A_DIRECTION,
                    A_STATUS, A_MASK, A_BITOP: s_axi_bresp <= RESP_OKAY;
                    default:                   s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writes without lane 0 carry no register bits and are dropped
    assign port_wr  = do_write & wlane0_q & (awaddr_q == A_PORT_DATA || awaddr_q == A_BITOP);
    assign bit_mask = PORT_W'(1) << wdata_q[2:0];
    assign rmw_val  = wdata_q[BITOP_VAL] ? (sample_q | bit_mask)
                                         : (sample_q & ~bit_mask);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            second_port_direction_q <= DIRECTION_RST;
            timer_pullup_config_q   <= OPTION_RST;
            mask_q                  <= '0;
        end else if (do_write && wlane0_q) begin
            case (awaddr_q)
                A_DIRECTION: second_port_direction_q <= wdata_q[PORT_W-1:0];
                A_OPTION:    timer_pullup_config_q   <= wdata_q[PORT_W-1:0];
                A_MASK:      mask_q                  <= wdata_q[ST_W-1:0];
                default:     mask_q                  <= mask_q;
            endcase
        end
    end

    // pending value waits for the end of the instruction cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pend_q     <= 1'b0;
            pend_val_q <= '0;
        end else if (port_wr) begin
            pend_q     <= 1'b1;
            pend_val_q <= (awaddr_q == A_BITOP) ? rmw_val : wdata_q[PORT_W-1:0];
        end else if (cyc_end) begin
            pend_q     <= 1'b0;
        end
    end

    // latch has no reset: unknown at power-on, kept through later resets
    always_ff @(posedge core_clk) begin
        if (pend_q && cyc_end) begin
            latch_q <= pend_val_q;
        end
    end

    // pins are captured at the start of each instruction cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sample_q <= '0;
        end else if (cyc_start) begin
            sample_q <= pin_s;
        end
    end

    // bus read channel, one read at a time
    assign rd_take = s_axi_arvalid & s_axi_arready;
    assign port_rd = rd_take & (s_axi_araddr == A_PORT_DATA);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= '0;
                case (s_axi_araddr)
                    A_PORT_DATA: s_axi_rdata[PORT_W-1:0] <= sample_q;
                    A_OPTION:    s_axi_rdata[PORT_W-1:0] <= timer_pullup_config_q;
                    A_DIRECTION: s_axi_rdata[PORT_W-1:0] <= second_port_direction_q;
                    A_STATUS:    s_axi_rdata[ST_W-1:0]   <= status_q;
                    A_MASK:      s_axi_rdata[ST_W-1:0]   <= mask_q;
                    A_BITOP:     s_axi_rdata             <= '0;
                    default:     s_axi_rresp             <= RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // change detection on the upper input pins
    assign mismatch = |((pin_s[7:4] ^ snap_q) & second_port_direction_q[7:4]);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            snap_q <= '0;
        end else if (port_rd || port_wr) begin
            snap_q <= pin_s[7:4];
        end
    end

    // pin level is used even when the pin is an output
    assign ext_edge = timer_pullup_config_q[OPT_EDGE_SEL]
                    ? (pin_s[0] & ~pin0_prev_q)
                    : (~pin_s[0] & pin0_prev_q);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin0_prev_q <= 1'b0;
        end else begin
            pin0_prev_q <= pin_s[0];
        end
    end

    // sticky status, read clears, a new event in the same cycle wins
    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_q <= '0;
        end else begin
            if (rd_take && s_axi_araddr == A_STATUS) begin
                status_q <= '0;
            end
            if (mismatch) begin
                status_q[ST_CHANGE] <= 1'b1;
            end
            if (ext_edge) begin
                status_q[ST_EXT_INT] <= 1'b1;
            end
        end
    end

    // programming mode takes pin six as input and hands pin seven over
    always_comb begin
        dir_eff = second_port_direction_q;
        if (prog_mode) begin
            dir_eff[PROG_CLK_PIN]  = 1'b1;
            dir_eff[PROG_DATA_PIN] = ~prog_data_oe;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin_oe          <= '0;
            pin_out         <= '0;
            pullup_en       <= '0;
            pin6_prog_clock <= 1'b0;
            pin7_prog_data  <= 1'b0;
            irq             <= 1'b0;
        end else begin
            pin_oe  <= ~dir_eff;
            pin_out <= latch_q & ~dir_eff;
            if (prog_mode) begin
                pin_out[PROG_DATA_PIN] <= prog_data_out & prog_data_oe;
            end
            pullup_en <= timer_pullup_config_q[OPT_PULLUP_DIS_N] ? '0 : dir_eff;
            pin6_prog_clock <= prog_mode & pin_s[PROG_CLK_PIN];
            pin7_prog_data  <= prog_mode & pin_s[PROG_DATA_PIN];
            irq             <= |(status_q & mask_q);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_commit_slot;
        pend_q && cyc_end;
    endsequence

    a_dir_opt_reset: assert property (
        $past(srst) |-> second_port_direction_q == DIRECTION_RST
                        && timer_pullup_config_q == OPTION_RST)
        else $error("direction or option not all ones after reset");
    a_oe_follows_dir: assert property (
        !prog_mode |=> pin_oe == ~$past(second_port_direction_q))
        else $error("output enable does not follow direction");
    a_pullup_gating: assert property (
        timer_pullup_config_q[OPT_PULLUP_DIS_N] |=> pullup_en == 8'h00)
        else $error("pull-up on while disabled");
    a_pullup_inputs: assert property (
        !prog_mode && !timer_pullup_config_q[OPT_PULLUP_DIS_N]
        |=> pullup_en == $past(second_port_direction_q))
        else $error("pull-up not matching input pins");
    a_latch_at_end: assert property (s_commit_slot |=> latch_q == $past(pend_val_q))
        else $error("latch not written at cycle end");
    a_sample_at_start: assert property (!$past(cyc_start) |-> $stable(sample_q))
        else $error("pin sample moved outside cycle start");
    a_change_flag_set: assert property (mismatch |=> status_q[ST_CHANGE])
        else $error("mismatch did not set change flag");
    a_access_ends_mismatch: assert property (port_rd |=> snap_q == $past(pin_s[7:4]))
        else $error("port read did not refresh change snapshot");
    a_ext_edge_flag: assert property (ext_edge |=> status_q[ST_EXT_INT])
        else $error("selected pin zero edge did not set flag");
    a_prog_clock_input: assert property (prog_mode |=> !pin_oe[PROG_CLK_PIN])
        else $error("programming clock pin driven in programming mode");
endmodule // bidir_port
`default_nettype wire

// ---- pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_model
    import port_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic [PORT_W-1:0] pin_out,
    input  wire logic [PORT_W-1:0] pin_oe,
    input  wire logic [PORT_W-1:0] pullup_en,
    input  wire logic [PORT_W-1:0] ext_val,
    input  wire logic [PORT_W-1:0] ext_oe,
    output logic      [PORT_W-1:0] pin_lvl
);
    logic [PORT_W-1:0] float_q;

    // a floating pin flips every cycle, so pin_sync never settles on it and holds the last stable level
    initial float_q = 8'h55;
    always @(posedge core_clk) float_q <= ~float_q;

    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (pin_oe[i]) begin
                pin_lvl[i] = pin_out[i];
            end else if (ext_oe[i]) begin
                pin_lvl[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin_lvl[i] = 1'b1;
            end else begin
                pin_lvl[i] = float_q[i];
            end
        end
    end
endmodule // pin_model
`default_nettype wire

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire  logic             core_clk,
    input  wire  logic             srst,
    input  wire  logic [WIDTH-1:0] async_in,
    output logic       [WIDTH-1:0] stable_q
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // a bit moves only once the second and third stages agree
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_q     <= '0;
            s2_q     <= '0;
            s3_q     <= '0;
            stable_q <= '0;
        end else begin
            s1_q     <= async_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            stable_q <= (s2_q & ~(s2_q ^ s3_q)) | (stable_q & (s2_q ^ s3_q));
        end
    end
endmodule // pin_sync
`default_nettype wire

// ---- port_pkg.sv ----
package port_pkg;
    localparam int          PORT_W           = 8;
    localparam int          AXI_AW           = 12;
    // printed offsets are register indices; byte address is four times the index
    localparam int          IDX_PORT_DATA    = 'h06;
    localparam int          IDX_OPTION       = 'h81;
    localparam int          IDX_DIRECTION    = 'h86;
    localparam logic [11:0] A_PORT_DATA      = 12'(4 * IDX_PORT_DATA);
    localparam logic [11:0] A_OPTION         = 12'(4 * IDX_OPTION);
    localparam logic [11:0] A_DIRECTION      = 12'(4 * IDX_DIRECTION);
    localparam logic [11:0] A_STATUS         = 12'h300;
    localparam logic [11:0] A_MASK           = 12'h304;
    localparam logic [11:0] A_BITOP          = 12'h308;
    localparam logic [7:0]  OPTION_RST       = 8'hFF;
    localparam logic [7:0]  DIRECTION_RST    = 8'hFF;
    localparam int          OPT_PULLUP_DIS_N = 7;
    localparam int          OPT_EDGE_SEL     = 6;
    localparam int          ST_CHANGE        = 0;
    localparam int          ST_EXT_INT       = 1;
    localparam int          ST_W             = 2;
    localparam int          BITOP_VAL        = 3;
    localparam int          PROG_CLK_PIN     = 6;
    localparam int          PROG_DATA_PIN    = 7;
    localparam int          CLK_MHZ          = 100;
    localparam int          INSTR_NS         = 40;
    localparam int          INSTR_CLKS       = (INSTR_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;
endpackage

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
    import port_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              srst = 1'b1;
    logic [AXI_AW-1:0] s_axi_awaddr = '0;
    logic [AXI_AW-1:0] s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0;
    logic [31:0]       s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 4'hF;
    logic [1:0]        s_axi_bresp;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_awready;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_wready;
    logic              s_axi_bvalid;
    logic              s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_arready;
    logic              s_axi_rvalid;
    logic              s_axi_rready = 1'b0;
    logic [PORT_W-1:0] pin_in;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    logic [PORT_W-1:0] pullup_en;
    logic [PORT_W-1:0] ext_val = '0;
    logic [PORT_W-1:0] ext_oe = '0;
    logic              prog_mode = 1'b0;
    logic              prog_data_out = 1'b0;
    logic              prog_data_oe = 1'b0;
    logic              pin6_prog_clock;
    logic              pin7_prog_data;
    logic              irq;
    logic [31:0]       rd;
    logic [1:0]        rsp;
    int                n_errors = 0;
    int                cmp_count = 0;

    always #5 core_clk = ~core_clk;

    bidir_port i_bidir_port (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pullup_en,
        .prog_mode, .prog_data_out, .prog_data_oe, .pin6_prog_clock, .pin7_prog_data, .irq);

    pin_model i_pin_model (.core_clk, .pin_out, .pin_oe, .pullup_en, .ext_val, .ext_oe,
        .pin_lvl(pin_in));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        chk_val({24'h0, got}, {24'h0, exp});
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_val({30'h0, got}, {30'h0, exp});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 100) n_errors++;
        @(posedge core_clk);
    endtask

    task automatic rd_reg(input logic [11:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 100) n_errors++;
        @(posedge core_clk);
    endtask

    // covers the commit phase, the pin sync and the next sample point
    task automatic settle;
        repeat (12) @(posedge core_clk);
    endtask

    task automatic t_reset;
        rd_reg(A_DIRECTION);
        chk_val(rd, 32'hFF);
        rd_reg(A_OPTION);
        chk_val(rd, 32'hFF);
        chk_pin(pullup_en, 8'h00);
        chk_pin(pin_oe, 8'h00);
        rd_reg(12'hFFC);
        chk_resp(rsp, RESP_SLVERR);
        // a write without lane 0 must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(A_DIRECTION, 32'h00);
        s_axi_wstrb <= 4'hF;
        rd_reg(A_DIRECTION);
        chk_val(rd, 32'hFF);
        wr(12'hFFC, 32'h0);
        chk_resp(rsp, RESP_SLVERR);
        $display("test reset done");
    endtask

    task automatic t_drive;
        wr(A_PORT_DATA, 32'hA5);
        chk_resp(rsp, RESP_OKAY);
        wr(A_DIRECTION, 32'h00);
        settle;
        chk_pin(pin_oe, 8'hFF);
        chk_pin(pin_out, 8'hA5);
        rd_reg(A_PORT_DATA);
        chk_val(rd, 32'hA5);
        $display("test drive done");
    endtask

    task automatic t_keep;
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk_pin(pin_oe, 8'h00);
        rd_reg(A_DIRECTION);
        chk_val(rd, 32'hFF);
        wr(A_DIRECTION, 32'h00);
        settle;
        chk_pin(pin_out, 8'hA5);
        $display("test keep done");
    endtask

    task automatic t_pullup;
        wr(A_DIRECTION, 32'hF0);
        wr(A_OPTION, 32'h7F);
        settle;
        chk_pin(pullup_en, 8'hF0);
        rd_reg(A_PORT_DATA);
        chk_val(rd, 32'hF5);
        wr(A_OPTION, 32'hFF);
        settle;
        chk_pin(pullup_en, 8'h00);
        $display("test pullup done");
    endtask

    task automatic t_rmw;
        wr(A_DIRECTION, 32'h0F);
        ext_val <= 8'h09;
        ext_oe <= 8'h0F;
        settle;
        rd_reg(A_PORT_DATA);
        chk_val(rd, 32'hA9);
        wr(A_BITOP, 32'h9);
        wr(A_BITOP, 32'h7);
        ext_oe <= 8'h00;
        wr(A_DIRECTION, 32'h00);
        settle;
        // set bit 1 was lost: the second op re-read input pin 1 as low
        chk_pin(pin_out, 8'h29);
        rd_reg(A_PORT_DATA);
        chk_val(rd, 32'h29);
        $display("test rmw done");
    endtask

    task automatic t_change;
        wr(A_DIRECTION, 32'hFF);
        ext_val <= 8'h00;
        ext_oe <= 8'hFF;
        settle;
        wr(A_MASK, 32'h1);
        rd_reg(A_PORT_DATA);
        rd_reg(A_STATUS);
        rd_reg(A_STATUS);
        chk_val(rd, 32'h0);
        ext_val <= 8'h04;
        settle;
        rd_reg(A_STATUS);
        chk_val(rd, 32'h0);
        ext_val <= 8'h24;
        settle;
        chk_pin({7'h0, irq}, 8'h01);
        rd_reg(A_STATUS);
        chk_val(rd, 32'h1);
        rd_reg(A_STATUS);
        chk_val(rd, 32'h1);
        rd_reg(A_PORT_DATA);
        rd_reg(A_STATUS);
        rd_reg(A_STATUS);
        chk_val(rd, 32'h0);
        repeat (3) @(posedge core_clk);
        chk_pin({7'h0, irq}, 8'h00);
        $display("test change done");
    endtask

    task automatic t_ext;
        wr(A_MASK, 32'h2);
        ext_val <= 8'h25;
        settle;
        chk_pin({7'h0, irq}, 8'h01);
        rd_reg(A_STATUS);
        chk_val(rd, 32'h2);
        wr(A_OPTION, 32'hBF);
        ext_val <= 8'h24;
        settle;
        rd_reg(A_STATUS);
        chk_val(rd, 32'h2);
        ext_val <= 8'h25;
        settle;
        rd_reg(A_STATUS);
        chk_val(rd, 32'h0);
        $display("test ext done");
    endtask

    task automatic t_prog;
        ext_val <= 8'hC0;
        ext_oe <= 8'hC0;
        prog_mode <= 1'b1;
        settle;
        chk_pin({6'h0, pin7_prog_data, pin6_prog_clock}, 8'h03);
        ext_oe <= 8'h40;
        prog_data_oe <= 1'b1;
        prog_data_out <= 1'b1;
        // all pins set as outputs: pin six must still stay an input
        wr(A_DIRECTION, 32'h00);
        settle;
        chk_pin({pin_oe[7], pin_out[7], pin7_prog_data, pin_oe[6], pin6_prog_clock, 3'h0},
                8'hE8);
        prog_mode <= 1'b0;
        prog_data_oe <= 1'b0;
        settle;
        chk_pin({7'h0, pin6_prog_clock}, 8'h00);
        chk_pin(pin_oe, 8'hFF);
        $display("test prog done");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_reset;
        t_drive;
        t_keep;
        t_pullup;
        t_rmw;
        t_change;
        t_ext;
        t_prog;
        tally_and_finish;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
